// ---- include/dmx_consts.svh ----
// Offsets, field positions, reset values and codes of the DMA/DRAM block
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH

// Register byte offsets
`define DMX_OFF_CTRL   8'h00
`define DMX_OFF_BANK   8'h04
`define DMX_OFF_ADDR   8'h08
`define DMX_OFF_COUNT  8'h0c
`define DMX_OFF_STATUS 8'h10

// Channel control fields, bit 0 is the least significant
`define DMX_CTRL_EN     31
`define DMX_CTRL_DIR    29
`define DMX_CTRL_TW_HI  27
`define DMX_CTRL_TW_LO  26
`define DMX_CTRL_XM_EN  24
`define DMX_CTRL_MD_HI  22
`define DMX_CTRL_MD_LO  21
`define DMX_CTRL_BURST  6

// Bank configuration fields
`define DMX_BANK_BW_HI  16
`define DMX_BANK_BW_LO  15
`define DMX_BANK_PAGE   11

// Reset values
`define DMX_CTRL_RST   32'h0000_0000
`define DMX_BANK_RST   32'h0001_0000
`define DMX_ADDR_RST   32'h0000_0000
`define DMX_COUNT_RST  16'h0000

// Codes
`define DMX_MODE_BUF   2'h0
`define DMX_MODE_FLY   2'h1
`define DMX_WID_BYTE   2'h0
`define DMX_WID_HALF   2'h1
`define DMX_WID_WORD   2'h2
`define DMX_SIZE_BURST 2'h3
`define DMX_LANES_BYTE 4'h1
`define DMX_LANES_HALF 4'h3
`define DMX_LANES_WORD 4'hf

`endif

// ---- include/dmx_pkg.sv ----
// Types shared by the DMA/DRAM block
package dmx_pkg;

  typedef enum logic [2:0]
  {
    DS_IDLE = 3'h0,
    DS_ROW  = 3'h1,
    DS_COL  = 3'h3,
    DS_PAGE = 3'h2,
    DS_PRE  = 3'h6
  } dmx_dram_state_e;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_PER   = 3'h1,
    ST_MEM   = 3'h3,
    ST_GRANT = 3'h2,
    ST_XMEM  = 3'h6
  } dmx_state_e;

  typedef struct packed
  {
    logic        start;
    logic        wr;
    logic        keep;
    logic [3:0]  lanes;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmx_dram_req_s;

endpackage

// ---- hdl/dmx_dram_seq.sv ----
// DRAM cycle sequencer: row, column, page hold and precharge
`timescale 1ns/1ps
`include "dmx_consts.svh"

module dmx_dram_seq
  import dmx_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire dmx_dram_req_s req_i,
  input  wire logic [31:0]   rdata_i,
  output logic               ras_n_o,
  output logic [3:0]         cas_n_o,
  output logic               we_n_o,
  output logic [31:0]        addr_o,
  output logic [31:0]        wdata_o,
  output logic               data_oe_o,
  output logic [31:0]        rdata_o,
  output logic               done_o,
  output logic               open_o
);

  dmx_dram_state_e state;

  ////////////////////////////////////////////////////////////////////////
  // Three-cycle access; page mode keeps the row open between beats
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state     <= DS_IDLE;
      ras_n_o   <= 1'b1;
      cas_n_o   <= 4'hf;
      we_n_o    <= 1'b1;
      addr_o    <= 32'h0000_0000;
      wdata_o   <= 32'h0000_0000;
      data_oe_o <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      done_o    <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      unique case (state)
        DS_IDLE:
        begin
          if (req_i.start)
          begin
            ras_n_o   <= 1'b0;
            we_n_o    <= ~req_i.wr;
            addr_o    <= req_i.addr;
            wdata_o   <= req_i.wdata;
            data_oe_o <= req_i.wr;
            state     <= DS_ROW;
          end
        end
        DS_ROW:
        begin
          cas_n_o <= ~req_i.lanes;
          state   <= DS_COL;
        end
        DS_COL:
        begin
          cas_n_o <= 4'hf;
          rdata_o <= rdata_i;
          done_o  <= 1'b1;
          if (req_i.keep)
            state <= DS_PAGE;
          else
          begin
            ras_n_o   <= 1'b1;
            we_n_o    <= 1'b1;
            data_oe_o <= 1'b0;
            state     <= DS_PRE;
          end
        end
        DS_PAGE:
        begin
          // Next beat reuses the open row, saving the row cycle
          if (req_i.start)
          begin
            addr_o    <= req_i.addr;
            wdata_o   <= req_i.wdata;
            we_n_o    <= ~req_i.wr;
            data_oe_o <= req_i.wr;
            cas_n_o   <= ~req_i.lanes;
            state     <= DS_COL;
          end
          else if (!req_i.keep)
          begin
            ras_n_o   <= 1'b1;
            we_n_o    <= 1'b1;
            data_oe_o <= 1'b0;
            state     <= DS_PRE;
          end
        end
        DS_PRE:
          state <= DS_IDLE;
        default:
          state <= DS_IDLE;
      endcase
    end
  end

  assign open_o = (state == DS_PAGE);

endmodule

// ---- hdl/dmx_top.sv ----
// DMA channel and external master access to DRAM, Wishbone registers
`timescale 1ns/1ps
`include "dmx_consts.svh"

module dmx_top
  import dmx_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        DMA_REQUEST_IN_I,
  output logic             DMA_ACKNOWLEDGE_OUT_O,
  input  wire logic        CHANNEL3_REQUEST_IN_I,
  output logic             CHANNEL3_ACKNOWLEDGE_OUT_O,
  input  wire logic        EOT_PIN_I,
  output logic             EOT_PIN_O,
  output logic             EOT_PIN_OE_O,
  input  wire logic        OE_PIN_I,
  output logic             OE_PIN_N_O,
  output logic             OE_PIN_OE_O,
  input  wire logic        BUS_HOLD_REQUEST_I,
  output logic             BUS_HOLD_GRANT_O,
  input  wire logic        EXT_WRITE_I,
  input  wire logic [31:0] EXT_ADDR_I,
  input  wire logic [3:0]  WBE_I,
  output logic      [3:0]  WBE_O,
  output logic             WBE_OE_O,
  output logic             RAS_N_O,
  output logic      [3:0]  COLUMN_STROBE_LANES_N_O,
  output logic             DRAM_WE_N_O,
  output logic      [31:0] DRAM_ADDR_O,
  input  wire logic [31:0] DATA_I,
  output logic      [31:0] DATA_O,
  output logic             DATA_OE_O
);

  logic [31:0]        dma_channel_control;
  logic [31:0]        dram_bank_configuration;
  logic [31:0]        dma_addr;
  logic [COUNT_W-1:0] dma_count;
  logic               width_err;
  dmx_state_e         state;
  dmx_dram_req_s      req;
  logic [31:0]        buf_data;
  logic               seq_done;
  logic               seq_open;
  logic [31:0]        seq_rdata;
  logic [31:0]        seq_wdata;
  logic               seq_oe;
  logic               per_to_mem;
  logic               sw_start;

  logic               wb_hit;
  logic [1:0]         xfer_mode;
  logic [1:0]         bank_width;
  logic [3:0]         bank_lanes;
  logic               width_ok;
  logic               fly;
  logic               burst;
  logic               page;
  logic               xm_en;
  logic               x_burst;
  logic [31:0]        x_addr;
  logic               dma_go;
  logic               more_beats;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign xfer_mode  = dma_channel_control[`DMX_CTRL_MD_HI:`DMX_CTRL_MD_LO];
  assign bank_width =
    dram_bank_configuration[`DMX_BANK_BW_HI:`DMX_BANK_BW_LO];
  assign fly   = (xfer_mode == `DMX_MODE_FLY);
  assign burst = dma_channel_control[`DMX_CTRL_BURST];
  assign page  = dram_bank_configuration[`DMX_BANK_PAGE];
  assign xm_en = dma_channel_control[`DMX_CTRL_XM_EN];
  assign per_to_mem = dma_channel_control[`DMX_CTRL_DIR];
  assign width_ok =
    (dma_channel_control[`DMX_CTRL_TW_HI:`DMX_CTRL_TW_LO] == bank_width)
    && ((xfer_mode == `DMX_MODE_BUF) || fly);

  always_comb
  begin
    unique case (bank_width)
      `DMX_WID_BYTE: bank_lanes = `DMX_LANES_BYTE;
      `DMX_WID_HALF: bank_lanes = `DMX_LANES_HALF;
      default:       bank_lanes = `DMX_LANES_WORD;
    endcase
  end

  // Address bits 4,5 sit at 27,26 and 30,31 at 1,0 in this numbering
  always_comb
  begin
    x_addr     = EXT_ADDR_I;
    x_addr[27] = WBE_I[0];
    x_addr[26] = WBE_I[1];
    x_addr[1]  = WBE_I[2];
    x_addr[0]  = WBE_I[3];
  end

  // Size bits ride on the terminal count and output enable pins
  assign x_burst = ({EOT_PIN_I, OE_PIN_I} == `DMX_SIZE_BURST)
                   && page;

  assign dma_go = dma_channel_control[`DMX_CTRL_EN] && DMA_REQUEST_IN_I
                  && (dma_count != '0) && width_ok && !seq_open;
  assign more_beats = fly && burst && page && DMA_REQUEST_IN_I
                      && (dma_count > COUNT_W'(1));

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state, unmapped reads return zero
  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign sw_start = wb_hit && WB_WE_I && (WB_ADR_I == `DMX_OFF_CTRL);

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_hit && !WB_WE_I)
      begin
        unique case (WB_ADR_I)
          `DMX_OFF_CTRL:   WB_DAT_O <= dma_channel_control;
          `DMX_OFF_BANK:   WB_DAT_O <= dram_bank_configuration;
          `DMX_OFF_ADDR:   WB_DAT_O <= dma_addr;
          `DMX_OFF_COUNT:  WB_DAT_O <= 32'(dma_count);
          `DMX_OFF_STATUS:
            WB_DAT_O <= {26'h0, width_err, BUS_HOLD_GRANT_O,
                         (state != ST_IDLE), state};
          default:         WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software writes; hardware clears enable and advances address/count
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      dma_channel_control     <= `DMX_CTRL_RST;
      dram_bank_configuration <= `DMX_BANK_RST;
      dma_addr                <= `DMX_ADDR_RST;
      dma_count               <= COUNT_W'(`DMX_COUNT_RST);
    end
    else
    begin
      if (seq_done && (state == ST_MEM))
      begin
        dma_addr  <= dma_addr + 32'(bank_lanes[3] ? 4 :
                                    bank_lanes[1] ? 2 : 1);
        dma_count <= dma_count - COUNT_W'(1);
        if (dma_count == COUNT_W'(1))
          dma_channel_control[`DMX_CTRL_EN] <= 1'b0;
      end
      if (wb_hit && WB_WE_I)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (WB_SEL_I[i])
          begin
            unique case (WB_ADR_I)
              `DMX_OFF_CTRL:
                dma_channel_control[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
              `DMX_OFF_BANK:
                dram_bank_configuration[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
              `DMX_OFF_ADDR:
                dma_addr[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
              default:
                ;
            endcase
          end
        end
        if ((WB_ADR_I == `DMX_OFF_COUNT) && (WB_SEL_I[1:0] == 2'h3))
          dma_count <= COUNT_W'(WB_DAT_I[15:0]);
      end
    end
  end

  // Mismatched widths are flagged; a control write clears it unless the old control is still enabled with a mismatch
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
      width_err <= 1'b0;
    else if (dma_channel_control[`DMX_CTRL_EN] && !width_ok)
      width_err <= 1'b1;
    else if (sw_start)
      width_err <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencing; hold requests win only between transfers
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      state                      <= ST_IDLE;
      req                        <= '0;
      buf_data                   <= 32'h0000_0000;
      DMA_ACKNOWLEDGE_OUT_O      <= 1'b0;
      CHANNEL3_ACKNOWLEDGE_OUT_O <= 1'b0;
      BUS_HOLD_GRANT_O           <= 1'b0;
      EOT_PIN_O                  <= 1'b0;
    end
    else
    begin
      req.start                  <= 1'b0;
      CHANNEL3_ACKNOWLEDGE_OUT_O <= 1'b0;
      EOT_PIN_O                  <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (BUS_HOLD_REQUEST_I)
          begin
            BUS_HOLD_GRANT_O <= 1'b1;
            state            <= ST_GRANT;
          end
          else if (dma_go)
          begin
            req.lanes <= bank_lanes;
            req.addr  <= dma_addr;
            req.wr    <= per_to_mem;
            req.keep  <= fly && burst && page;
            if (fly)
            begin
              // Peripheral owns the data bus for the whole beat
              req.start             <= 1'b1;
              DMA_ACKNOWLEDGE_OUT_O <= 1'b1;
              state                 <= ST_MEM;
            end
            else if (per_to_mem)
            begin
              DMA_ACKNOWLEDGE_OUT_O <= 1'b1;
              state                 <= ST_PER;
            end
            else
            begin
              req.start <= 1'b1;
              state     <= ST_MEM;
            end
          end
        end
        ST_PER:
        begin
          // Buffered leg on the peripheral side
          DMA_ACKNOWLEDGE_OUT_O <= 1'b0;
          if (per_to_mem)
          begin
            req.wdata <= DATA_I;
            req.start <= 1'b1;
            state     <= ST_MEM;
          end
          else
            state <= ST_IDLE;
        end
        ST_MEM:
        begin
          if (seq_done)
          begin
            if (more_beats)
            begin
              req.keep  <= 1'b1;
              req.start <= 1'b1;
              req.addr  <= dma_addr + 32'(bank_lanes[3] ? 4 :
                                          bank_lanes[1] ? 2 : 1);
            end
            else
            begin
              req.keep              <= 1'b0;
              DMA_ACKNOWLEDGE_OUT_O <= 1'b0;
              EOT_PIN_O             <= (dma_count == COUNT_W'(1));
              if (!fly && !per_to_mem)
              begin
                buf_data              <= seq_rdata;
                DMA_ACKNOWLEDGE_OUT_O <= 1'b1;
                state                 <= ST_PER;
              end
              else
                state <= ST_IDLE;
            end
          end
        end
        ST_GRANT:
        begin
          if (!BUS_HOLD_REQUEST_I)
          begin
            BUS_HOLD_GRANT_O <= 1'b0;
            state            <= ST_IDLE;
          end
          else if (xm_en && CHANNEL3_REQUEST_IN_I && !seq_open)
          begin
            req.start <= 1'b1;
            req.wr    <= EXT_WRITE_I;
            req.addr  <= x_addr;
            req.lanes <= bank_lanes;
            req.wdata <= DATA_I;
            req.keep  <= x_burst;
            state     <= ST_XMEM;
          end
        end
        ST_XMEM:
        begin
          // Stop beats as soon as request or either size bit falls
          if (!CHANNEL3_REQUEST_IN_I || !x_burst)
            req.keep <= 1'b0;
          if (seq_done)
          begin
            CHANNEL3_ACKNOWLEDGE_OUT_O <= 1'b1;
            if (req.keep && CHANNEL3_REQUEST_IN_I && x_burst)
            begin
              req.start <= 1'b1;
              req.wr    <= EXT_WRITE_I;
              req.addr  <= x_addr;
              req.wdata <= DATA_I;
            end
            else
            begin
              req.keep <= 1'b0;
              state    <= ST_GRANT;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared pin directions and peripheral data drive
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      EOT_PIN_OE_O <= 1'b0;
      OE_PIN_N_O   <= 1'b1;
      OE_PIN_OE_O  <= 1'b1;
      WBE_O        <= 4'hf;
      WBE_OE_O     <= 1'b1;
      DATA_O       <= 32'h0000_0000;
      DATA_OE_O    <= 1'b0;
    end
    else
    begin
      // Size pins turn to inputs: terminal count whenever master access is enabled, output enable only while the master owns the bus
      EOT_PIN_OE_O <= !xm_en;
      OE_PIN_OE_O  <= !(xm_en && BUS_HOLD_GRANT_O);
      OE_PIN_N_O   <= 1'b1;
      WBE_O        <= 4'hf;
      WBE_OE_O     <= !BUS_HOLD_GRANT_O;
      if ((state == ST_PER) && !per_to_mem)
      begin
        DATA_O    <= buf_data;
        DATA_OE_O <= 1'b1;
      end
      else
      begin
        DATA_O    <= seq_wdata;
        DATA_OE_O <= seq_oe && !fly && !BUS_HOLD_GRANT_O;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  dmx_dram_seq u_seq
  (
    .clk_i     (MCLK_I),
    .reset_n_i (RESET_N_I),
    .req_i     (req),
    .rdata_i   (DATA_I),
    .ras_n_o   (RAS_N_O),
    .cas_n_o   (COLUMN_STROBE_LANES_N_O),
    .we_n_o    (DRAM_WE_N_O),
    .addr_o    (DRAM_ADDR_O),
    .wdata_o   (seq_wdata),
    .data_oe_o (seq_oe),
    .rdata_o   (seq_rdata),
    .done_o    (seq_done),
    .open_o    (seq_open)
  );

endmodule

// ---- verif/dmx_top_assertions.sv ----
// Port checker for the DMA and external master DRAM block
`timescale 1ns/1ps

module dmx_top_chk
(
  input wire logic       MCLK_I,
  input wire logic       RESET_N_I,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic [3:0] COLUMN_STROBE_LANES_N_O,
  input wire logic       RAS_N_O,
  input wire logic       BUS_HOLD_REQUEST_I,
  input wire logic       BUS_HOLD_GRANT_O,
  input wire logic       CHANNEL3_REQUEST_IN_I,
  input wire logic       CHANNEL3_ACKNOWLEDGE_OUT_O,
  input wire logic       EOT_PIN_I,
  input wire logic       EOT_PIN_OE_O,
  input wire logic       OE_PIN_I,
  input wire logic       OE_PIN_OE_O,
  input wire logic       WBE_OE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows_req : assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("register access not answered in one cycle");
  a_ack_one_cycle : assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("register ack longer than one cycle");
  a_lanes_legal : assert property (
    $fell(COLUMN_STROBE_LANES_N_O[0])
    |-> COLUMN_STROBE_LANES_N_O inside {4'he, 4'hc, 4'h0})
    else $error("column strobe lane set not byte, half or word");
  a_lane0_leads : assert property (
    COLUMN_STROBE_LANES_N_O[0] |-> &COLUMN_STROBE_LANES_N_O)
    else $error("upper strobe lane active without lane 0");
  a_grant_follows_hold : assert property (
    BUS_HOLD_REQUEST_I |-> ##[0:40] BUS_HOLD_GRANT_O)
    else $error("hold request not granted");
  a_grant_drops : assert property (
    BUS_HOLD_GRANT_O && !BUS_HOLD_REQUEST_I |-> ##[0:40] !BUS_HOLD_GRANT_O)
    else $error("grant kept after hold request dropped");
  a_req_stops_beats : assert property (
    !CHANNEL3_REQUEST_IN_I [*6] |-> !CHANNEL3_ACKNOWLEDGE_OUT_O)
    else $error("master beat without request");
  a_size_ends_burst : assert property (
    BUS_HOLD_GRANT_O && CHANNEL3_ACKNOWLEDGE_OUT_O && !(EOT_PIN_I && OE_PIN_I)
    |-> ##[0:6] RAS_N_O)
    else $error("access not closed with size inputs not both high");
  a_pins_released : assert property (
    (BUS_HOLD_GRANT_O && !EOT_PIN_OE_O) [*2] |-> !OE_PIN_OE_O && !WBE_OE_O)
    else $error("shared pins still driven under external master");

  c_dram_beat : cover property ($fell(COLUMN_STROBE_LANES_N_O[0]));
  c_grant : cover property ($rose(BUS_HOLD_GRANT_O));
  c_master_beat : cover property (CHANNEL3_ACKNOWLEDGE_OUT_O);
endmodule

bind dmx_top dmx_top_chk u_chk (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .COLUMN_STROBE_LANES_N_O(COLUMN_STROBE_LANES_N_O), .RAS_N_O(RAS_N_O),
  .BUS_HOLD_REQUEST_I(BUS_HOLD_REQUEST_I), .BUS_HOLD_GRANT_O(BUS_HOLD_GRANT_O),
  .CHANNEL3_REQUEST_IN_I(CHANNEL3_REQUEST_IN_I),
  .CHANNEL3_ACKNOWLEDGE_OUT_O(CHANNEL3_ACKNOWLEDGE_OUT_O),
  .EOT_PIN_I(EOT_PIN_I), .EOT_PIN_OE_O(EOT_PIN_OE_O), .OE_PIN_I(OE_PIN_I),
  .OE_PIN_OE_O(OE_PIN_OE_O), .WBE_OE_O(WBE_OE_O));

// ---- verif/dmx_far_side.sv ----
// Peripheral and DRAM data model on the far side of the block
`timescale 1ns/1ps

module dmx_far_side
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] want_i,
  input  wire logic       ack_i,
  input  wire logic [3:0] cas_n_i,
  input  wire logic       we_n_i,
  input  wire logic       data_oe_i,
  output logic            req_o,
  output logic            done_o,
  output logic [31:0]     data_o
);
  logic        column_strobe_lane0_q = 1'b1;
  logic        ack_q = 1'b0;
  logic [3:0]  cnt = 4'h0;
  logic [31:0] last = 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    column_strobe_lane0_q <= cas_n_i[0];
    ack_q  <= ack_i;
    last   <= data_o;
    if (!go_i)
      cnt <= 4'h0;
    else if (column_strobe_lane0_q && !cas_n_i[0])
      cnt <= cnt + 4'h1;
  end

  assign req_o  = go_i && (cnt < want_i);
  assign done_o = go_i && (cnt >= want_i);
  // Word held one cycle past ack; an undriven bus toggles, never holds
  assign data_o = (ack_i || ack_q) ? 32'h5a3c_96e1 :
                  (!cas_n_i[0] && we_n_i && !data_oe_i) ? 32'hd0d0_1234 :
                  ~last;
endmodule

// ---- verif/tb.sv ----
// Testbench for the DMA and external master DRAM block
`timescale 1ns/1ps
`include "dmx_consts.svh"

module tb;
  logic        MCLK_I = 1'b0;
  logic        RESET_N_I = 1'b0;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0;
  logic        BUS_HOLD_REQUEST_I = 1'b0;
  logic        EXT_WRITE_I = 1'b0;
  logic        go = 1'b0;
  logic        xmode = 1'b0;
  logic        xsz = 1'b0;
  logic        bysz = 1'b0;
  logic        pdone_q = 1'b0;
  logic [3:0]  want = 4'h0;
  logic [31:0] WB_DAT_O, DATA_O, DRAM_ADDR_O, DATA_I, q;
  logic [3:0]  WBE_O, WBE_I, COLUMN_STROBE_LANES_N_O, lanes;
  logic        WB_ACK_O, DMA_ACKNOWLEDGE_OUT_O, CHANNEL3_ACKNOWLEDGE_OUT_O;
  logic        EOT_PIN_O, EOT_PIN_OE_O, OE_PIN_N_O, OE_PIN_OE_O, WBE_OE_O;
  logic        BUS_HOLD_GRANT_O, RAS_N_O, DRAM_WE_N_O, DATA_OE_O;
  logic        preq, pdone, column_strobe_lane0_q, EOT_PIN_I, OE_PIN_I;
  logic [31:0] wdat, adr;
  int          fail_count = 0;
  int          n_checks = 0;
  int          beats, ch3, eots, oe_seen;
  logic [3:0]  lx [3] = '{`DMX_LANES_BYTE, `DMX_LANES_HALF, `DMX_LANES_WORD};

  always #12.5 MCLK_I = ~MCLK_I;

  assign EOT_PIN_I = EOT_PIN_OE_O ? EOT_PIN_O : (xsz & ~(bysz & pdone));
  assign OE_PIN_I = OE_PIN_OE_O ? OE_PIN_N_O : xsz;
  assign WBE_I = WBE_OE_O ? WBE_O : 4'ha;

  dmx_top dut (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(4'hf), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .DMA_REQUEST_IN_I(preq & ~xmode),
    .DMA_ACKNOWLEDGE_OUT_O(DMA_ACKNOWLEDGE_OUT_O),
    .CHANNEL3_REQUEST_IN_I(xmode & (bysz ? go & ~pdone_q : preq)),
    .CHANNEL3_ACKNOWLEDGE_OUT_O(CHANNEL3_ACKNOWLEDGE_OUT_O),
    .EOT_PIN_I(EOT_PIN_I), .EOT_PIN_O(EOT_PIN_O), .EOT_PIN_OE_O(EOT_PIN_OE_O),
    .OE_PIN_I(OE_PIN_I), .OE_PIN_N_O(OE_PIN_N_O), .OE_PIN_OE_O(OE_PIN_OE_O),
    .BUS_HOLD_REQUEST_I(BUS_HOLD_REQUEST_I),
    .BUS_HOLD_GRANT_O(BUS_HOLD_GRANT_O), .EXT_WRITE_I(EXT_WRITE_I),
    .EXT_ADDR_I(32'h0000_1234), .WBE_I(WBE_I), .WBE_O(WBE_O),
    .WBE_OE_O(WBE_OE_O), .RAS_N_O(RAS_N_O),
    .COLUMN_STROBE_LANES_N_O(COLUMN_STROBE_LANES_N_O),
    .DRAM_WE_N_O(DRAM_WE_N_O), .DRAM_ADDR_O(DRAM_ADDR_O), .DATA_I(DATA_I),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O));

  dmx_far_side u_far (
    .clk_i(MCLK_I), .go_i(go), .want_i(want), .ack_i(DMA_ACKNOWLEDGE_OUT_O),
    .cas_n_i(COLUMN_STROBE_LANES_N_O), .we_n_i(DRAM_WE_N_O),
    .data_oe_i(DATA_OE_O), .req_o(preq), .done_o(pdone), .data_o(DATA_I));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge MCLK_I)
  begin
    pdone_q <= pdone;
    column_strobe_lane0_q <= COLUMN_STROBE_LANES_N_O[0];
    if (column_strobe_lane0_q === 1'b1 && COLUMN_STROBE_LANES_N_O[0] === 1'b0)
    begin
      beats++;
      lanes = ~COLUMN_STROBE_LANES_N_O;
      adr = DRAM_ADDR_O;
      if (DATA_OE_O === 1'b1)
        wdat = DATA_O;
    end
    ch3 += (CHANNEL3_ACKNOWLEDGE_OUT_O === 1'b1);
    eots += (EOT_PIN_O === 1'b1);
    oe_seen |= (DATA_OE_O === 1'b1);
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge MCLK_I);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    k = 0;
    do
    begin
      @(posedge MCLK_I);
      k++;
    end
    while (WB_ACK_O !== 1'b1 && k < 50);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (k >= 50)
      chk("register ack", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    wb(1'b0, a, 32'h0);
    chk(w, e, q);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] w, md, input logic b);
    ctl = 32'h0;
    ctl[`DMX_CTRL_EN] = 1'b1;
    ctl[`DMX_CTRL_DIR] = 1'b1;
    ctl[`DMX_CTRL_TW_HI:`DMX_CTRL_TW_LO] = w;
    ctl[`DMX_CTRL_MD_HI:`DMX_CTRL_MD_LO] = md;
    ctl[`DMX_CTRL_BURST] = b;
  endfunction

  function automatic logic [31:0] bank(input logic [1:0] w, input logic pg);
    bank = 32'h0;
    bank[`DMX_BANK_BW_HI:`DMX_BANK_BW_LO] = w;
    bank[`DMX_BANK_PAGE] = pg;
  endfunction

  task automatic dma(input logic [1:0] bw, tw, md, input logic b,
                     input logic [3:0] n, input logic [15:0] cnt);
    int k;
    wb(1'b1, `DMX_OFF_CTRL, 32'h0);
    wb(1'b1, `DMX_OFF_BANK, bank(bw, b));
    wb(1'b1, `DMX_OFF_COUNT, {16'h0, cnt});
    beats = 0;
    eots = 0;
    oe_seen = 0;
    want <= n;
    go <= 1'b1;
    wb(1'b1, `DMX_OFF_CTRL, ctl(tw, md, b));
    repeat (6) @(posedge MCLK_I);
    k = 0;
    do
    begin
      wb(1'b0, `DMX_OFF_STATUS, 32'h0);
      k++;
    end
    while (q[3] !== 1'b0 && k < 40);
    chk("dma finished", 32'h0, {31'h0, q[3]});
    go <= 1'b0;
  endtask

  task automatic xm(input logic [3:0] n, input logic wr, sz, bs);
    int k;
    ch3 = 0;
    beats = 0;
    EXT_WRITE_I <= wr;
    xsz <= sz;
    bysz <= bs;
    want <= n;
    go <= 1'b1;
    for (k = 0; k < 80 && beats < n; k++)
      @(posedge MCLK_I);
    repeat (12) @(posedge MCLK_I);
    go <= 1'b0;
    xsz <= 1'b0;
    repeat (4) @(posedge MCLK_I);
    chk("master beats", n, ch3);
  endtask

  task automatic grant_wait(input logic v);
    int k;
    for (k = 0; k < 40 && BUS_HOLD_GRANT_O !== v; k++)
      @(posedge MCLK_I);
    chk("hold grant", v, BUS_HOLD_GRANT_O);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    fail_count++;
    tally_and_finish;
  end

  initial
  begin
    repeat (8) @(posedge MCLK_I);
    RESET_N_I <= 1'b1;
    rd(`DMX_OFF_CTRL, `DMX_CTRL_RST, "control reset");
    rd(`DMX_OFF_BANK, `DMX_BANK_RST, "bank reset");
    rd(8'h20, 32'h0, "unmapped read");
    wb(1'b1, `DMX_OFF_STATUS, 32'hffff_ffff);
    rd(`DMX_OFF_STATUS, 32'h0, "status read only");
    $display("test registers done");
    for (int w = 0; w < 3; w++)
    begin
      dma(2'(w), 2'(w), `DMX_MODE_FLY, 1'b0, 4'h1, 16'h1);
      chk("lanes", {28'h0, lx[w]}, {28'h0, lanes});
      chk("single beats", 1, beats);
      chk("flyby data drive", 0, oe_seen);
      chk("end pulses", 1, eots);
    end
    $display("test flyby single done");
    dma(`DMX_WID_WORD, `DMX_WID_WORD, `DMX_MODE_FLY, 1'b1, 4'h3, 16'h8);
    chk("burst beats", 3, beats);
    rd(`DMX_OFF_COUNT, 32'h5, "count left");
    $display("test flyby burst done");
    dma(`DMX_WID_WORD, `DMX_WID_WORD, `DMX_MODE_BUF, 1'b0, 4'h1, 16'h4);
    chk("buffered beats", 1, beats);
    chk("buffered data", 32'h5a3c_96e1, wdat);
    $display("test buffered done");
    dma(`DMX_WID_BYTE, `DMX_WID_WORD, `DMX_MODE_FLY, 1'b0, 4'h1, 16'h1);
    chk("mismatch beats", 0, beats);
    rd(`DMX_OFF_STATUS, 32'h20, "width error");
    $display("test width mismatch done");
    xmode <= 1'b1;
    wb(1'b1, `DMX_OFF_BANK, bank(`DMX_WID_WORD, 1'b1));
    wb(1'b1, `DMX_OFF_CTRL, 32'h1 << `DMX_CTRL_XM_EN);
    BUS_HOLD_REQUEST_I <= 1'b1;
    grant_wait(1'b1);
    repeat (2) @(posedge MCLK_I);
    chk("size pin released", 0, EOT_PIN_OE_O);
    chk("byte enables released", 0, WBE_OE_O);
    xm(4'h1, 1'b0, 1'b0, 1'b0);
    chk("master address", 32'h0400_1235, adr);
    xm(4'h3, 1'b1, 1'b1, 1'b0);
    xm(4'h2, 1'b1, 1'b1, 1'b1);
    BUS_HOLD_REQUEST_I <= 1'b0;
    grant_wait(1'b0);
    $display("test external master done");
    tally_and_finish;
  end
endmodule
